// >>> core_pkg.sv
/*
  constants, codes and helper functions shared by the completion and execution core.
  assumes a single core clock; every file that uses it imports core_pkg::*.
*/
package core_pkg;
  localparam int         CQ_DEPTH   = 6;
  localparam int         REN_N      = 6;
  localparam int         MUL_FAST   = 2;
  localparam int         MUL_SLOW   = 4;
  localparam logic [31:0] WORD_RESET = 32'h0;
  localparam logic [2:0] UNIT_INT      = 3'h0;
  localparam logic [2:0] UNIT_FLOAT    = 3'h1;
  localparam logic [2:0] UNIT_LOAD     = 3'h2;
  localparam logic [2:0] UNIT_STORE    = 3'h3;
  localparam logic [2:0] UNIT_SYS      = 3'h4;
  localparam logic [2:0] UNIT_BR_CTR   = 3'h5;
  localparam logic [2:0] UNIT_BR_PLAIN = 3'h6;
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_OR  = 3'h3;
  localparam logic [2:0] OP_SHL = 3'h4;
  localparam logic [2:0] OP_CLZ = 3'h5;
  localparam logic [2:0] OP_MUL = 3'h6;
  localparam logic [2:0] OP_DIV = 3'h7;

  function automatic logic [2:0] idx_add(input logic [2:0] i, input logic [2:0] n);
    logic [3:0] s;
    s = {1'b0, i} + {1'b0, n};
    if (s >= 4'(CQ_DEPTH)) s = s - 4'(CQ_DEPTH);
    return s[2:0];
  endfunction

  // distance of slot i above the bottom slot
  function automatic logic [2:0] idx_off(input logic [2:0] i, input logic [2:0] head);
    logic [3:0] s;
    s = (i >= head) ? {1'b0, i} - {1'b0, head} : {1'b0, i} + 4'(CQ_DEPTH) - {1'b0, head};
    return s[2:0];
  endfunction

  function automatic logic [31:0] clz32(input logic [31:0] a);
    logic [31:0] n;
    logic        hit;
    n   = 32'h0;
    hit = 1'b0;
    for (int k = 31; k >= 0; k--) begin
      if (a[k]) hit = 1'b1;
      if (!hit) n = n + 32'h1;
    end
    return n;
  endfunction

  // one subunit answers per op; divide by zero yields zero
  function automatic logic [31:0] int_result(input logic [2:0] op, input logic [31:0] a,
                                             input logic [31:0] b);
    logic [63:0] p;
    p = {32'h0, a} * {32'h0, b};
    case (op)
      OP_ADD:  return a + b;
      OP_SUB:  return a - b;
      OP_AND:  return a & b;
      OP_OR:   return a | b;
      OP_SHL:  return a << b[4:0];
      OP_CLZ:  return clz32(a);
      OP_MUL:  return p[31:0];
      default: return (b == 32'h0) ? 32'h0 : a / b;
    endcase
  endfunction

  // early exit when both operands fit in 16 bits
  function automatic logic [2:0] md_cycles(input logic [31:0] a, input logic [31:0] b);
    return (a[31:16] == 16'h0 && b[31:16] == 16'h0) ? 3'(MUL_FAST) : 3'(MUL_SLOW);
  endfunction
endpackage

// >>> reg_memory.sv
/*
  architected register array with two write ports and one registered read port.
  assumes write port 1 carries the younger of two same-cycle retirements.
*/
`timescale 1ns/10ps
module reg_memory #(
  parameter int W = 32,
  parameter int N = 32
) (
  input  wire logic           clock,
  input  wire logic           we0,
  input  wire logic [4:0]     wa0,
  input  wire logic [W-1:0]   wd0,
  input  wire logic           we1,
  input  wire logic [4:0]     wa1,
  input  wire logic [W-1:0]   wd1,
  input  wire logic [4:0]     ra,
  output logic      [W-1:0]   rd_q
);
  logic [W-1:0] mem [N];

  // younger write lands last
  always_ff @(posedge clock) begin
    if (we0) mem[wa0] <= wd0;
    if (we1) mem[wa1] <= wd1;
    rd_q <= mem[ra];
  end
endmodule

// >>> fp_pipe.sv
/*
  three-stage float pipe: multiply, add, normalize; never stalls downstream.
  assumes the caller presents one op at a time and honours in_ready.
*/
`timescale 1ns/10ps
module fp_pipe (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        in_valid,
  input  wire logic        in_double,
  input  wire logic [3:0]  in_tag,
  input  wire logic [63:0] in_a,
  input  wire logic [63:0] in_b,
  output logic             in_ready,
  output logic             out_valid_q,
  output logic      [3:0]  out_tag_q,
  output logic      [63:0] out_data_q
);
  import core_pkg::*;
  logic        m_v_q, m_hold_q, a_v_q;
  logic [3:0]  m_tag_q, a_tag_q;
  logic [63:0] m_a_q, m_b_q, a_sum_q;
  logic [63:0] prod;
  logic        m_leave;
  logic [63:0] norm;

  assign prod     = {32'h0, m_a_q[31:0]} * {32'h0, m_b_q[31:0]};
  // double precision spends a second cycle here
  assign m_leave  = m_v_q && !m_hold_q;
  assign in_ready = !m_v_q || m_leave;

  // shift left until the top bit is set; zero stays zero
  always_comb begin
    norm = a_sum_q;
    for (int k = 0; k < 64; k++) begin
      if (norm != 64'h0 && !norm[63]) norm = norm << 1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      m_v_q       <= 1'b0;
      m_hold_q    <= 1'b0;
      a_v_q       <= 1'b0;
      out_valid_q <= 1'b0;
      out_tag_q   <= 4'h0;
      out_data_q  <= 64'h0;
    end else begin
      if (in_valid && in_ready) begin
        m_v_q    <= 1'b1;
        m_hold_q <= in_double;
        m_tag_q  <= in_tag;
        m_a_q    <= in_a;
        m_b_q    <= in_b;
      end else if (m_leave) begin
        m_v_q <= 1'b0;
      end else begin
        m_hold_q <= 1'b0;
      end
      a_v_q       <= m_leave;
      a_tag_q     <= m_tag_q;
      a_sum_q     <= prod + m_b_q;
      out_valid_q <= a_v_q;
      out_tag_q   <= a_tag_q;
      out_data_q  <= norm;
    end
  end
endmodule

// >>> completion_core.sv
/*
  completion queue, rename accounting, integer, float, load/store and system units.
  assumes the dispatcher supplies ready operands and waits on disp_ready_q;
  the data cache answers a request in the same cycle it is presented.
*/
`timescale 1ns/10ps
module completion_core (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        disp_valid,
  input  wire logic [2:0]  disp_unit,
  input  wire logic [2:0]  disp_op,
  input  wire logic        disp_double,
  input  wire logic        disp_serial,
  input  wire logic        disp_guarded,
  input  wire logic        disp_has_dest,
  input  wire logic [4:0]  disp_dest,
  input  wire logic [63:0] disp_a,
  input  wire logic [63:0] disp_b,
  output logic             disp_ready_q,
  input  wire logic        flush_valid,
  input  wire logic [2:0]  flush_keep,
  output logic             cache_req_q,
  output logic             cache_we_q,
  output logic      [31:0] cache_addr_q,
  output logic      [63:0] cache_wdata_q,
  input  wire logic        cache_hit,
  input  wire logic [63:0] cache_rdata,
  input  wire logic [2:0]  ren_rd_slot,
  output logic             ren_rd_valid_q,
  output logic      [63:0] ren_rd_data_q,
  input  wire logic [4:0]  arch_rd_addr,
  output logic      [31:0] general_register_rd_q,
  output logic      [63:0] float_register_rd_q,
  output logic      [31:0] count_register_q,
  output logic      [31:0] link_register_q,
  output logic      [1:0]  retire_count_q,
  output logic      [2:0]  cq_used_q
);
  import core_pkg::*;
  localparam int NW = 5;

  // ************************************************************
  // completion queue state
  // ************************************************************
  logic        v_q [CQ_DEPTH];
  logic        done_q [CQ_DEPTH];
  logic        gen_q [CQ_DEPTH];
  logic        ser_q [CQ_DEPTH];
  logic        hd_q [CQ_DEPTH];
  logic        fpd_q [CQ_DEPTH];
  logic [2:0]  unit_q [CQ_DEPTH];
  logic [4:0]  dest_q [CQ_DEPTH];
  logic [63:0] res_q [CQ_DEPTH];
  logic [31:0] addr_q [CQ_DEPTH];
  logic [2:0]  head_q, cnt_q, ren_q;

  function automatic logic tag_live(input logic [3:0] t);
    return v_q[t[2:0]] && gen_q[t[2:0]] == t[3];
  endfunction

  // ************************************************************
  // dispatch decode
  // ************************************************************
  logic       take, alloc, need_ren, to_simple, to_full, to_fp, to_ld, to_sr;
  logic [2:0] tail, h1;
  logic [3:0] new_tag;

  assign take      = disp_valid && disp_ready_q && !flush_valid;
  assign alloc     = take && disp_unit != UNIT_BR_PLAIN;
  assign need_ren  = alloc && disp_has_dest;
  assign tail      = idx_add(head_q, cnt_q);
  assign h1        = idx_add(head_q, 3'h1);
  assign new_tag   = {~gen_q[tail], tail};
  // mul and div to full unit
  assign to_simple = alloc && disp_unit == UNIT_INT && disp_op < OP_MUL;
  assign to_full   = alloc && disp_unit == UNIT_INT && disp_op >= OP_MUL;
  assign to_fp     = alloc && disp_unit == UNIT_FLOAT;
  assign to_ld     = alloc && disp_unit == UNIT_LOAD;
  assign to_sr     = alloc && disp_unit == UNIT_SYS;

  // ************************************************************
  // integer units
  // ************************************************************
  logic        si_v_q, fi_v_q, fi_done;
  logic [3:0]  si_tag_q, fi_tag_q;
  logic [2:0]  si_op_q, fi_op_q, fi_cnt_q;
  logic [31:0] si_a_q, si_b_q, fi_a_q, fi_b_q;

  assign fi_done = fi_v_q && fi_cnt_q == 3'h1;

  always_ff @(posedge clock) begin
    if (rst) begin
      si_v_q <= 1'b0;
      fi_v_q <= 1'b0;
    end else begin
      si_v_q <= to_simple;
      if (to_full) fi_v_q <= 1'b1;
      else if (fi_done) fi_v_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (to_simple) begin
      si_tag_q <= new_tag;
      si_op_q  <= disp_op;
      si_a_q   <= disp_a[31:0];
      si_b_q   <= disp_b[31:0];
    end
    if (to_full) begin
      fi_tag_q <= new_tag;
      fi_op_q  <= disp_op;
      fi_a_q   <= disp_a[31:0];
      fi_b_q   <= disp_b[31:0];
      fi_cnt_q <= (disp_op == OP_MUL) ? md_cycles(disp_a[31:0], disp_b[31:0]) : 3'(MUL_SLOW);
    end else if (fi_v_q && !fi_done) begin
      fi_cnt_q <= fi_cnt_q - 3'h1;
    end
  end

  // ************************************************************
  // float reservation station and pipe
  // ************************************************************
  logic        fr_v_q, fp_in_ready, fp_out_v;
  logic        fr_dbl_q;
  logic [3:0]  fr_tag_q, fp_out_tag;
  logic [63:0] fr_a_q, fr_b_q, fp_out_data;

  always_ff @(posedge clock) begin
    if (rst) fr_v_q <= 1'b0;
    else if (to_fp) fr_v_q <= 1'b1;
    else if (fp_in_ready) fr_v_q <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (to_fp) begin
      fr_tag_q <= new_tag;
      fr_dbl_q <= disp_double;
      fr_a_q   <= disp_a;
      fr_b_q   <= disp_b;
    end
  end

  fp_pipe u_fp (
    .clock       (clock),
    .rst         (rst),
    .in_valid    (fr_v_q),
    .in_double   (fr_dbl_q),
    .in_tag      (fr_tag_q),
    .in_a        (fr_a_q),
    .in_b        (fr_b_q),
    .in_ready    (fp_in_ready),
    .out_valid_q (fp_out_v),
    .out_tag_q   (fp_out_tag),
    .out_data_q  (fp_out_data)
  );

  // ************************************************************
  // load/store unit and system unit
  // ************************************************************
  logic        ld_v_q, ld_sent_q, ld_grd_q, ld_fin, ld_go, ld_kill;
  logic        sr_v_q, sr_ser_q, sr_go, sr_kill;
  logic [3:0]  ld_tag_q, sr_tag_q;
  logic [31:0] ld_addr_q;
  logic [63:0] sr_a_q;
  logic        r0, r1, st0, st1, store_go;
  logic [2:0]  st_slot;

  assign ld_kill  = flush_valid && idx_off(ld_tag_q[2:0], head_q) >= flush_keep;
  assign sr_kill  = flush_valid && idx_off(sr_tag_q[2:0], head_q) >= flush_keep;
  assign ld_fin   = ld_v_q && ld_sent_q && cache_hit;
  assign ld_go    = ld_v_q && !ld_fin && !ld_kill && !store_go
                    && (!ld_grd_q || ld_tag_q[2:0] == head_q);
  assign sr_go    = sr_v_q && !sr_kill && (!sr_ser_q || sr_tag_q[2:0] == head_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      ld_v_q    <= 1'b0;
      ld_sent_q <= 1'b0;
      sr_v_q    <= 1'b0;
    end else begin
      ld_v_q    <= to_ld || (ld_v_q && !ld_fin && !ld_kill);
      ld_sent_q <= ld_go;
      sr_v_q    <= to_sr || (sr_v_q && !sr_go && !sr_kill);
    end
  end

  always_ff @(posedge clock) begin
    if (to_ld) begin
      ld_tag_q  <= new_tag;
      ld_grd_q  <= disp_guarded;
      ld_addr_q <= disp_a[31:0] + disp_b[31:0];
    end
    if (to_sr) begin
      sr_tag_q <= new_tag;
      sr_ser_q <= disp_serial;
      sr_a_q   <= disp_a;
    end
  end

  // ************************************************************
  // retirement and cache port
  // ************************************************************
  // two bottom slots in order
  assign st0      = unit_q[head_q] == UNIT_STORE;
  assign st1      = unit_q[h1] == UNIT_STORE;
  assign r0       = !flush_valid && v_q[head_q] && done_q[head_q];
  assign r1       = r0 && v_q[h1] && done_q[h1] && !(st0 && st1);
  assign store_go = (r0 && st0) || (r1 && st1);
  assign st_slot  = (r0 && st0) ? head_q : h1;

  always_ff @(posedge clock) begin
    if (rst) begin
      cache_req_q   <= 1'b0;
      cache_we_q    <= 1'b0;
      cache_addr_q  <= WORD_RESET;
      cache_wdata_q <= 64'h0;
    end else begin
      cache_req_q   <= store_go || ld_go;
      cache_we_q    <= store_go;
      cache_addr_q  <= store_go ? addr_q[st_slot] : ld_addr_q;
      cache_wdata_q <= res_q[st_slot];
    end
  end

  // ************************************************************
  // result writes into rename storage
  // ************************************************************
  logic        wr_en [NW];
  logic [3:0]  wr_tag [NW];
  logic [63:0] wr_data [NW];

  assign wr_en[0]   = si_v_q && tag_live(si_tag_q);
  assign wr_tag[0]  = si_tag_q;
  assign wr_data[0] = {32'h0, int_result(si_op_q, si_a_q, si_b_q)};
  assign wr_en[1]   = fi_done && tag_live(fi_tag_q);
  assign wr_tag[1]  = fi_tag_q;
  assign wr_data[1] = {32'h0, int_result(fi_op_q, fi_a_q, fi_b_q)};
  assign wr_en[2]   = fp_out_v && tag_live(fp_out_tag);
  assign wr_tag[2]  = fp_out_tag;
  assign wr_data[2] = fp_out_data;
  assign wr_en[3]   = ld_fin && tag_live(ld_tag_q);
  assign wr_tag[3]  = ld_tag_q;
  assign wr_data[3] = cache_rdata;
  assign wr_en[4]   = sr_go && tag_live(sr_tag_q);
  assign wr_tag[4]  = sr_tag_q;
  assign wr_data[4] = sr_a_q;

  always_ff @(posedge clock) begin
    for (int i = 0; i < CQ_DEPTH; i++) begin
      if (rst) begin
        v_q[i]    <= 1'b0;
        done_q[i] <= 1'b0;
        gen_q[i]  <= 1'b0;
      end else if (flush_valid) begin
        if (idx_off(3'(i), head_q) >= flush_keep) v_q[i] <= 1'b0;
      end else begin
        if ((r0 && 3'(i) == head_q) || (r1 && 3'(i) == h1)) v_q[i] <= 1'b0;
        if (alloc && 3'(i) == tail) begin
          v_q[i]    <= 1'b1;
          gen_q[i]  <= ~gen_q[i];
          done_q[i] <= disp_unit == UNIT_BR_CTR || disp_unit == UNIT_STORE;
        end
        for (int u = 0; u < NW; u++) begin
          if (wr_en[u] && wr_tag[u][2:0] == 3'(i)) done_q[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < CQ_DEPTH; i++) begin
      if (alloc && 3'(i) == tail) begin
        unit_q[i] <= disp_unit;
        dest_q[i] <= disp_dest;
        hd_q[i]   <= disp_has_dest;
        ser_q[i]  <= disp_unit == UNIT_SYS && disp_serial;
        fpd_q[i]  <= disp_unit == UNIT_FLOAT || (disp_unit == UNIT_LOAD && disp_op[0]);
        res_q[i]  <= (disp_unit == UNIT_STORE) ? disp_b : disp_a;
        addr_q[i] <= disp_a[31:0];
      end
      for (int u = 0; u < NW; u++) begin
        if (wr_en[u] && wr_tag[u][2:0] == 3'(i)) res_q[i] <= wr_data[u];
      end
    end
  end

  // ************************************************************
  // queue and rename counters
  // ************************************************************
  logic [2:0] keep_eff, drop_ren, cnt_d, ren_d, head_d;
  logic [1:0] rcnt, rdest;
  logic       arch0, arch1;

  assign keep_eff = (flush_keep < cnt_q) ? flush_keep : cnt_q;
  assign rcnt     = {1'b0, r0} + {1'b0, r1};
  assign arch0    = r0 && hd_q[head_q] && unit_q[head_q] != UNIT_STORE;
  assign arch1    = r1 && hd_q[h1] && unit_q[h1] != UNIT_STORE;
  assign rdest    = {1'b0, r0 && hd_q[head_q]} + {1'b0, r1 && hd_q[h1]};
  assign head_d   = idx_add(head_q, {1'b0, rcnt});
  assign cnt_d    = flush_valid ? keep_eff : cnt_q - {1'b0, rcnt} + {2'b0, alloc};
  assign ren_d    = flush_valid ? ren_q - drop_ren : ren_q + {2'b0, need_ren} - {1'b0, rdest};

  always_comb begin
    drop_ren = 3'h0;
    for (int i = 0; i < CQ_DEPTH; i++) begin
      if (v_q[i] && hd_q[i] && idx_off(3'(i), head_q) >= flush_keep) drop_ren = drop_ren + 3'h1;
    end
  end

  // conservative: every station must drain before the next dispatch
  always_ff @(posedge clock) begin
    if (rst) begin
      head_q         <= 3'h0;
      cnt_q          <= 3'h0;
      ren_q          <= 3'h0;
      disp_ready_q   <= 1'b0;
      retire_count_q <= 2'h0;
      cq_used_q      <= 3'h0;
    end else begin
      head_q         <= flush_valid ? head_q : head_d;
      cnt_q          <= cnt_d;
      ren_q          <= ren_d;
      disp_ready_q   <= cnt_d < 3'(CQ_DEPTH) && ren_d < 3'(REN_N) && !to_simple
                        && !(to_full || (fi_v_q && !fi_done)) && !(to_fp || fr_v_q)
                        && !(to_ld || ld_v_q) && !(to_sr || sr_v_q);
      retire_count_q <= rcnt;
      cq_used_q      <= cnt_d;
    end
  end

  // ************************************************************
  // architected state and rename read port
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      count_register_q <= WORD_RESET;
      link_register_q  <= WORD_RESET;
      ren_rd_valid_q   <= 1'b0;
      ren_rd_data_q    <= 64'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if ((k == 0 ? r0 : r1) && unit_q[k == 0 ? head_q : h1] == UNIT_BR_CTR) begin
          if (dest_q[k == 0 ? head_q : h1][0]) link_register_q <= res_q[k == 0 ? head_q : h1][31:0];
          else count_register_q <= res_q[k == 0 ? head_q : h1][31:0];
        end
      end
      ren_rd_valid_q <= v_q[ren_rd_slot] && done_q[ren_rd_slot] && !ser_q[ren_rd_slot];
      ren_rd_data_q  <= res_q[ren_rd_slot];
    end
  end

  reg_memory #(.W(32), .N(32)) u_gpr (
    .clock (clock),
    .we0   (arch0 && !fpd_q[head_q] && unit_q[head_q] != UNIT_BR_CTR),
    .wa0   (dest_q[head_q]),
    .wd0   (res_q[head_q][31:0]),
    .we1   (arch1 && !fpd_q[h1] && unit_q[h1] != UNIT_BR_CTR),
    .wa1   (dest_q[h1]),
    .wd1   (res_q[h1][31:0]),
    .ra    (arch_rd_addr),
    .rd_q  (general_register_rd_q)
  );

  reg_memory #(.W(64), .N(32)) u_fpr (
    .clock (clock),
    .we0   (arch0 && fpd_q[head_q]),
    .wa0   (dest_q[head_q]),
    .wd0   (res_q[head_q]),
    .we1   (arch1 && fpd_q[h1]),
    .wa1   (dest_q[h1]),
    .wd1   (res_q[h1]),
    .ra    (arch_rd_addr),
    .rd_q  (float_register_rd_q)
  );
endmodule

// >>> l1_cache_model.sv
/*
  data cache model on the far side of the load/store port.
  assumes one request per cycle, answered in the cycle it stands.
*/
`timescale 1ns/10ps
module l1_cache_model (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  output logic             hit,
  output logic      [63:0] rdata
);
  // ************
  // cache answer
  // ************
  logic [63:0] noise_q = 64'h5a5a_5a5a_5a5a_5a5a;
  logic        missed_q = 1'b0;
  // same-cycle hit, one miss when slow
  assign hit   = req && !we && (!slow || missed_q);
  // idle data churns so a stale sample never matches
  assign rdata = hit ? {~addr, addr} : noise_q;
  always_ff @(posedge clock) begin
    noise_q  <= ~noise_q + 64'h1;
    missed_q <= req && !we && !hit;
  end
endmodule

// >>> core_sva.sv
/*
  port assertions for completion_core.
  assumes one clock and a synchronous active-high rst.
*/
`timescale 1ns/10ps
module core_sva
  import core_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        disp_valid,
  input wire logic [2:0]  disp_unit,
  input wire logic [2:0]  disp_op,
  input wire logic        disp_double,
  input wire logic [63:0] disp_a,
  input wire logic [63:0] disp_b,
  input wire logic        disp_ready_q,
  input wire logic        flush_valid,
  input wire logic        cache_req_q,
  input wire logic        cache_we_q,
  input wire logic [31:0] cache_addr_q,
  input wire logic [1:0]  retire_count_q,
  input wire logic [2:0]  cq_used_q
);
  // ******
  // checks
  // ******
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire        take   = disp_valid && disp_ready_q && !flush_valid;
  wire        idle   = take && cq_used_q == 3'h0;
  wire        short  = disp_a[31:16] == 16'h0 && disp_b[31:16] == 16'h0;
  wire [31:0] ld_adr = disp_a[31:0] + disp_b[31:0];
  sequence int_take; idle && disp_unit == UNIT_INT; endsequence
  sequence mul_take; int_take ##0 disp_op == OP_MUL; endsequence
  sequence rd_req; cache_req_q && !cache_we_q; endsequence
  sequence fp_take; idle && disp_unit == UNIT_FLOAT; endsequence
  chk_queue_bound: assert property (cq_used_q <= 3'h6) else $error("queue over six");
  chk_slot_alloc: assert property (int_take |=> cq_used_q == 3'h1) else $error("no slot");
  chk_retire_cap: assert property (
    retire_count_q != 2'h3 && {1'b0, retire_count_q} <= $past(cq_used_q)) else $error("retire");
  chk_full_stall: assert property (cq_used_q == 3'h6 |-> !disp_ready_q) else $error("full");
  // branches and stores use no station, so they drop ready only when they fill the queue
  chk_take_stall: assert property (
    take && disp_unit < UNIT_BR_CTR && disp_unit != UNIT_STORE |=> !disp_ready_q)
    else $error("ready held");
  chk_fp_single: assert property (
    fp_take ##0 !disp_double |-> ##5 retire_count_q == 2'h0 ##1 retire_count_q == 2'h1)
    else $error("single latency");
  chk_fp_double: assert property (
    fp_take ##0 disp_double |-> ##6 retire_count_q == 2'h0 ##1 retire_count_q == 2'h1)
    else $error("double latency");
  chk_plain_branch: assert property (
    idle && disp_unit == UNIT_BR_PLAIN |=> cq_used_q == 3'h0) else $error("branch slot");
  chk_load_access: assert property (
    idle && disp_unit == UNIT_LOAD |-> ##2 rd_req ##0 cache_addr_q == $past(ld_adr, 2))
    else $error("load access");
  chk_int_ready: assert property (
    int_take ##0 disp_op < OP_MUL |=> !disp_ready_q ##1 disp_ready_q) else $error("int time");
  chk_mul_slow: assert property (mul_take ##0 !short |=> !disp_ready_q[*4]) else $error("mul");
  chk_mul_fast: assert property (
    mul_take ##0 short |=> !disp_ready_q[*2] ##[1:2] disp_ready_q) else $error("no early exit");
  chk_store_hold: assert property (
    cache_req_q && cache_we_q |-> $past(cq_used_q) != 3'h0) else $error("early store");
endmodule
bind completion_core core_sva u_sva (.clock, .rst, .disp_valid, .disp_unit, .disp_op, .disp_a,
  .disp_double, .disp_b, .disp_ready_q, .flush_valid, .cache_req_q, .cache_we_q, .cache_addr_q,
  .retire_count_q, .cq_used_q);

// >>> completion_core_tb.sv
/*
  self-checking bench for completion_core with a data cache model.
  assumes core_pkg, the core, the model and the checker are compiled first.
*/
`timescale 1ns/10ps
module completion_core_tb;
  import core_pkg::*;
  logic        clock, rst, disp_valid, disp_double, disp_serial, disp_guarded, disp_has_dest;
  logic        disp_ready_q, flush_valid, cache_req_q, cache_we_q, cache_hit, slow;
  logic [2:0]  disp_unit, disp_op, flush_keep, ren_rd_slot, cq_used_q;
  logic [4:0]  disp_dest, arch_rd_addr;
  logic [1:0]  retire_count_q;
  logic [31:0] cache_addr_q, general_register_rd_q, count_register_q, link_register_q;
  logic [63:0] disp_a, disp_b, cache_wdata_q, cache_rdata, float_register_rd_q;
  int          failures, cmp_count;
  completion_core dut (.clock, .rst, .disp_valid, .disp_unit, .disp_op, .disp_double, .disp_serial,
    .disp_guarded, .disp_has_dest, .disp_dest, .disp_a, .disp_b, .disp_ready_q, .flush_valid,
    .flush_keep, .cache_req_q, .cache_we_q, .cache_addr_q, .cache_wdata_q, .cache_hit,
    .cache_rdata, .ren_rd_slot, .ren_rd_valid_q(), .ren_rd_data_q(), .arch_rd_addr,
    .general_register_rd_q, .float_register_rd_q, .count_register_q, .link_register_q,
    .retire_count_q, .cq_used_q);
  l1_cache_model cache (.clock, .slow, .req(cache_req_q), .we(cache_we_q), .addr(cache_addr_q),
    .hit(cache_hit), .rdata(cache_rdata));
  // *****
  // tasks
  // *****
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // waits for ready so a refused request is never left standing;
  // at least one edge passes so valid never drops and rises in one step
  task automatic disp(input logic [2:0] u, op, input logic [63:0] a, b, input logic [4:0] d);
    for (int n = 0; n < 99; n++) begin
      @(negedge clock);
      if (disp_ready_q === 1'b1) break;
    end
    {disp_unit, disp_op, disp_a, disp_b, disp_dest} = {u, op, a, b, d};
    disp_has_dest = u != UNIT_STORE && u != UNIT_BR_PLAIN;
    disp_valid = 1'b1;
    @(negedge clock);
    disp_valid = 1'b0;
  endtask
  task automatic drain();
    for (int n = 0; n < 60 && cq_used_q !== 3'h0; n++) @(negedge clock);
  endtask
  task automatic rd(input logic [4:0] r);
    arch_rd_addr = r;
    @(negedge clock);
  endtask
  task automatic t_int();
    logic [31:0] e [8];
    e = '{32'hf3, 32'hed, 32'h0, 32'hf3, 32'h780, 32'h18, 32'h2d0, 32'h50};
    // empty queue before each op so the timing checks engage
    for (int k = 0; k < 8; k++) begin
      drain();
      disp(UNIT_INT, 3'(k), 64'hf0, 64'h3, 5'(k + 1));
    end
    drain();
    disp(UNIT_INT, OP_MUL, 64'h10000, 64'h3, 5'd9);
    drain();
    for (int k = 0; k < 8; k++) begin
      rd(5'(k + 1));
      check("int result", 64'(general_register_rd_q), 64'(e[k]));
    end
    rd(5'd9);
    check("long mul", 64'(general_register_rd_q), 64'h30000);
    $display("int test done");
  endtask
  task automatic t_branch();
    disp(UNIT_BR_PLAIN, 3'h0, 64'h0, 64'h0, 5'd0);
    check("plain branch slot", 64'(cq_used_q), 64'h0);
    disp(UNIT_BR_CTR, 3'h0, 64'h1234, 64'h0, 5'd0);
    disp(UNIT_BR_CTR, 3'h0, 64'h55, 64'h0, 5'd1);
    drain();
    // a younger link update is flushed before it can retire
    disp(UNIT_BR_CTR, 3'h0, 64'h77, 64'h0, 5'd1);
    flush_valid = 1'b1;
    @(negedge clock);
    flush_valid = 1'b0;
    @(negedge clock);
    check("count", 64'(count_register_q), 64'h1234);
    check("flushed slot", 64'(cq_used_q), 64'h0);
    check("link", 64'(link_register_q), 64'h55);
    $display("branch test done");
  endtask
  task automatic t_mem();
    disp(UNIT_STORE, 3'h0, 64'h100, 64'h0123456789abcdef, 5'd0);
    for (int n = 0; n < 20 && (cache_req_q & cache_we_q) !== 1'b1; n++) @(negedge clock);
    check("store addr", 64'(cache_addr_q), 64'h100);
    check("store data", cache_wdata_q, 64'h0123456789abcdef);
    for (int s = 0; s < 2; s++) begin
      drain();
      slow = s[0];
      disp_guarded = s[0];
      disp(UNIT_LOAD, 3'h0, 64'hfc, 64'h4, 5'(10 + s));
    end
    disp(UNIT_LOAD, 3'h1, 64'hfc, 64'h4, 5'd2);
    drain();
    rd(5'd10);
    check("load", 64'(general_register_rd_q), 64'h100);
    rd(5'd11);
    check("slow load", 64'(general_register_rd_q), 64'h100);
    rd(5'd2);
    check("float load", float_register_rd_q, 64'hfffffeff00000100);
    $display("memory test done");
  endtask
  // stand-in datapath: 2 * 3 + 3 = 9, normalized to the top bit
  task automatic t_fp();
    for (int s = 0; s < 2; s++) begin
      drain();
      disp_double = s[0];
      disp(UNIT_FLOAT, 3'h0, 64'h2, 64'h3, 5'(3 + s));
    end
    drain();
    for (int s = 0; s < 2; s++) begin
      rd(5'(3 + s));
      check("float result", float_register_rd_q, 64'h9000000000000000);
    end
    $display("float test done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ********
  // sequence
  // ********
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #(25 * 3000);
    failures++;
    end_sim();
  end
  initial begin
    {disp_valid, disp_double, disp_serial, disp_guarded, disp_has_dest, flush_valid, slow} = '0;
    {disp_unit, disp_op, flush_keep, ren_rd_slot, disp_dest, arch_rd_addr, disp_a, disp_b} = '0;
    failures = 0;
    cmp_count = 0;
    rst = 1'b1;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_int();
    t_branch();
    t_mem();
    t_fp();
    end_sim();
  end
endmodule
